// >>> hw/oam_endpoint_lookup.sv
// Endpoint lookup and loss-measurement counting for analyzer and rewriter stages.
// Assumes frame descriptors synchronous to clk, one per stage per cycle at most.
//
// Operation
// - Each frame gets one analyzer lookup and one rewriter lookup.
// - Analyzer maps by service index table entry: enable bit and endpoint index.
// - Rewriter maps by egress action: valid bit and endpoint index.
// - Unmapped frames fall to the port endpoint; that lookup always happens.
// - Disabled port endpoint means no processing for frames falling to it.
// - Port-mapped frame increments only that port endpoint's counters.
// - Service-mapped frame counts at service, optional server, and port.
// - Same three-layer hierarchy in analyzer and rewriter.
// - One active endpoint per stage updates counters for its hierarchy.
// - Active service updates itself, resident port, and enabled server.
// - Up-facing is transmit side in analyzer, receive side in rewriter.
// - Down-facing service counts at server and network-side port endpoint.
// - Up-facing service counts at itself, up server, user-side port.
// - Up-facing server active for own PDUs skips port counters.
// - Up to two up, two down endpoints plus port: five levels.
// - Non-OAM frames are data, counted, optionally discarded.
`include "oam_lookup_consts.svh"
`default_nettype none

module oam_endpoint_lookup #(
  parameter int NUM_EP = 32,
  parameter int NUM_SIDX = 64,
  parameter int NUM_PORTS = 8,
  parameter int CNT_W = 32
) (
  input wire logic clk,
  input wire logic nrst,
  input wire oam_lookup_pkg::ana_frame_s anaFrame,
  input wire oam_lookup_pkg::rew_frame_s rewFrame,
  output wire oam_lookup_pkg::lookup_s anaResult,
  output wire oam_lookup_pkg::lookup_s rewResult,
  input wire oam_lookup_pkg::axi_req_s axiReq,
  output wire oam_lookup_pkg::axi_rsp_s axiRsp
);
  import oam_lookup_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [NUM_SIDX-1:0][`AXI_DW-1:0] per_service_index_table;
    logic [NUM_EP-1:0][`AXI_DW-1:0] epCfg;
    logic [NUM_PORTS-1:0][`AXI_DW-1:0] portCfg;
    logic [NUM_EP-1:0][CNT_W-1:0] svcRx;
    logic [NUM_EP-1:0][CNT_W-1:0] svcTx;
    logic [NUM_PORTS-1:0][CNT_W-1:0] portRx;
    logic [NUM_PORTS-1:0][CNT_W-1:0] portTx;
    lookup_s ana;
    lookup_s rew;
    logic awHeld;
    logic [`AXI_AW-1:0] awAddr;
    logic wHeld;
    logic [`AXI_DW-1:0] wData;
    logic [3:0] wStrb;
    axi_rsp_s rsp;
  } state_s;

  state_s st_ff;
  state_s nxt_st;
  lookup_s nxtAna;
  lookup_s nxtRew;

  // ==========================================================================
  // Functions

  // One lookup; the active endpoint decides every counter touched this slot
  // single active endpoint
  function automatic lookup_s doLookup(input logic valid, input logic isRew,
                                       input logic mapOn, input logic [`EP_IDX_W-1:0] mapIdx,
                                       input logic [`PORT_IDX_W-1:0] port,
                                       input logic isOam);
    lookup_s r;
    logic [`AXI_DW-1:0] ep;
    logic [`AXI_DW-1:0] pc;
    logic [`EP_IDX_W-1:0] srv;
    logic svc;
    logic up;
    r = '0;
    ep = st_ff.epCfg[mapIdx];
    pc = st_ff.portCfg[port];
    srv = ep[`EPCFG_SRV_LSB +: `EP_IDX_W];
    svc = mapOn && (int'(mapIdx) < NUM_EP) && ep[`EPCFG_ENA];
    up = ep[`EPCFG_UP];
    r.port = port;
    if (svc) begin
      r.tx = isRew ? !up : up;
      r.svcOn = 1'b1;
      r.svcIdx = mapIdx;
      r.srvOn = ep[`EPCFG_SRV_ENA] && (int'(srv) < NUM_EP) && st_ff.epCfg[srv][`EPCFG_ENA];
      r.srvIdx = srv;
      r.portOn = pc[`PORTCFG_ENA] && !(up && ep[`EPCFG_IS_SRV] && isOam);
      r.processed = 1'b1;
      r.discard = !isOam && ep[`EPCFG_DISC];
    end else begin
      r.tx = isRew;
      r.portOn = pc[`PORTCFG_ENA];
      r.processed = pc[`PORTCFG_ENA];
      r.discard = pc[`PORTCFG_ENA] && !isOam && pc[`PORTCFG_DISC];
    end
    r.valid = 1'b1;
    if (!valid) begin
      r = '0;
    end
    return r;
  endfunction

  // Hit on a service or server endpoint counter in a given direction
  function automatic logic epHit(input lookup_s l, input int i, input logic tx);
    logic [`EP_IDX_W-1:0] idx;
    idx = `EP_IDX_W'(i);
    return (l.tx == tx) && ((l.svcOn && l.svcIdx == idx) || (l.srvOn && l.srvIdx == idx));
  endfunction

  function automatic logic portHit(input lookup_s l, input int i, input logic tx);
    return (l.tx == tx) && l.portOn && (l.port == `PORT_IDX_W'(i));
  endfunction

  // Sum of both stages so a shared counter never loses an increment
  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c, input logic a,
                                            input logic b);
    return c + CNT_W'(a) + CNT_W'(b);
  endfunction

  function automatic logic [`AXI_DW-1:0] mergeStrb(input logic [`AXI_DW-1:0] old,
                                                   input logic [`AXI_DW-1:0] din,
                                                   input logic [3:0] strb);
    logic [`AXI_DW-1:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = din[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Register read decode; unmapped words answer SLVERR with zero data
  function automatic logic [`AXI_DW+1:0] readWord(input logic [`AXI_AW-1:0] a);
    logic [3:0] blk;
    int i;
    logic [`AXI_DW-1:0] d;
    logic ok;
    blk = a[`BLK_LSB +: 4];
    i = int'(a[`BLK_LSB-1:`IDX_LSB]);
    d = '0;
    ok = 1'b1;
    if (blk == `BLK_IPT && i < NUM_SIDX) begin
      d = st_ff.per_service_index_table[i];
    end else if (blk == `BLK_EPCFG && i < NUM_EP) begin
      d = st_ff.epCfg[i];
    end else if (blk == `BLK_PORTCFG && i < NUM_PORTS) begin
      d = st_ff.portCfg[i];
    end else if (blk == `BLK_SVC_RX && i < NUM_EP) begin
      d = `AXI_DW'(st_ff.svcRx[i]);
    end else if (blk == `BLK_SVC_TX && i < NUM_EP) begin
      d = `AXI_DW'(st_ff.svcTx[i]);
    end else if (blk == `BLK_PORT_RX && i < NUM_PORTS) begin
      d = `AXI_DW'(st_ff.portRx[i]);
    end else if (blk == `BLK_PORT_TX && i < NUM_PORTS) begin
      d = `AXI_DW'(st_ff.portTx[i]);
    end else begin
      ok = 1'b0;
    end
    return {ok ? `RESP_OKAY : `RESP_SLVERR, d};
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    logic [`AXI_DW-1:0] tbl;
    logic [3:0] blk;
    int wi;
    logic wOk;
    tbl = '0;
    blk = '0;
    wi = 0;
    wOk = 1'b0;
    nxt_st = st_ff;
    tbl = st_ff.per_service_index_table[anaFrame.serviceIndex];
    nxtAna = doLookup(anaFrame.valid, 1'b0, tbl[`IPT_ENA],
                      tbl[`IPT_IDX_LSB +: `EP_IDX_W], anaFrame.port, anaFrame.isOam);
    nxtRew = doLookup(rewFrame.valid, 1'b1, rewFrame.egressEndpointIndexValid,
                      rewFrame.egressEndpointIndex, rewFrame.port, rewFrame.isOam);
    nxt_st.ana = nxtAna;
    nxt_st.rew = nxtRew;
    for (int i = 0; i < NUM_EP; i++) begin
      nxt_st.svcRx[i] = bump(st_ff.svcRx[i], epHit(nxtAna, i, 1'b0), epHit(nxtRew, i, 1'b0));
      nxt_st.svcTx[i] = bump(st_ff.svcTx[i], epHit(nxtAna, i, 1'b1), epHit(nxtRew, i, 1'b1));
    end
    for (int i = 0; i < NUM_PORTS; i++) begin
      nxt_st.portRx[i] = bump(st_ff.portRx[i], portHit(nxtAna, i, 1'b0),
                              portHit(nxtRew, i, 1'b0));
      nxt_st.portTx[i] = bump(st_ff.portTx[i], portHit(nxtAna, i, 1'b1),
                              portHit(nxtRew, i, 1'b1));
    end

    // Write channel: address and data taken in either order
    if (axiReq.awvalid && st_ff.rsp.awready) begin
      nxt_st.awHeld = 1'b1;
      nxt_st.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && st_ff.rsp.wready) begin
      nxt_st.wHeld = 1'b1;
      nxt_st.wData = axiReq.wdata;
      nxt_st.wStrb = axiReq.wstrb;
    end
    if (axiReq.bready && st_ff.rsp.bvalid) begin
      nxt_st.rsp.bvalid = 1'b0;
    end
    if (nxt_st.awHeld && nxt_st.wHeld && !nxt_st.rsp.bvalid) begin
      blk = nxt_st.awAddr[`BLK_LSB +: 4];
      wi = int'(nxt_st.awAddr[`BLK_LSB-1:`IDX_LSB]);
      wOk = 1'b1;
      // Config takes effect on the next frame; counters are read-only
      if (blk == `BLK_IPT && wi < NUM_SIDX) begin
        nxt_st.per_service_index_table[wi] = mergeStrb(st_ff.per_service_index_table[wi], nxt_st.wData, nxt_st.wStrb) & `IPT_MASK;
      end else if (blk == `BLK_EPCFG && wi < NUM_EP) begin
        nxt_st.epCfg[wi] = mergeStrb(st_ff.epCfg[wi], nxt_st.wData, nxt_st.wStrb)
                           & `EPCFG_MASK;
      end else if (blk == `BLK_PORTCFG && wi < NUM_PORTS) begin
        nxt_st.portCfg[wi] = mergeStrb(st_ff.portCfg[wi], nxt_st.wData, nxt_st.wStrb)
                             & `PORTCFG_MASK;
      end else begin
        wOk = readWord(nxt_st.awAddr) >> `AXI_DW == `RESP_OKAY;
      end
      nxt_st.rsp.bresp = wOk ? `RESP_OKAY : `RESP_SLVERR;
      nxt_st.rsp.bvalid = 1'b1;
      nxt_st.awHeld = 1'b0;
      nxt_st.wHeld = 1'b0;
    end
    nxt_st.rsp.awready = !nxt_st.awHeld && !nxt_st.rsp.bvalid;
    nxt_st.rsp.wready = !nxt_st.wHeld && !nxt_st.rsp.bvalid;

    // Read channel: one read in flight, answer one cycle after the address
    if (axiReq.rready && st_ff.rsp.rvalid) begin
      nxt_st.rsp.rvalid = 1'b0;
      nxt_st.rsp.arready = 1'b1;
    end
    if (axiReq.arvalid && st_ff.rsp.arready) begin
      {nxt_st.rsp.rresp, nxt_st.rsp.rdata} = readWord(axiReq.araddr);
      nxt_st.rsp.rvalid = 1'b1;
      nxt_st.rsp.arready = 1'b0;
    end
  end

  // Registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
      st_ff.rsp.awready <= 1'b1;
      st_ff.rsp.wready <= 1'b1;
      st_ff.rsp.arready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flops
  assign anaResult = st_ff.ana;
  assign rewResult = st_ff.rew;
  assign axiRsp = st_ff.rsp;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic [`AXI_DW-1:0] aTbl;
  logic [`AXI_DW-1:0] aEp;
  logic [`AXI_DW-1:0] rEp;
  logic aMap;
  logic rMap;
  logic aPortEna;
  assign aTbl = st_ff.per_service_index_table[anaFrame.serviceIndex];
  assign aEp = st_ff.epCfg[aTbl[`IPT_IDX_LSB +: `EP_IDX_W]];
  assign rEp = st_ff.epCfg[rewFrame.egressEndpointIndex];
  assign aMap = aTbl[`IPT_ENA] && aEp[`EPCFG_ENA]
                && int'(aTbl[`IPT_IDX_LSB +: `EP_IDX_W]) < NUM_EP;
  assign rMap = rewFrame.egressEndpointIndexValid && rEp[`EPCFG_ENA]
                && int'(rewFrame.egressEndpointIndex) < NUM_EP;
  assign aPortEna = st_ff.portCfg[anaFrame.port][`PORTCFG_ENA];

  sequence anaPortOnly;
    anaFrame.valid && !aTbl[`IPT_ENA] && aPortEna && !rewFrame.valid;
  endsequence

  sequence anaUpSvcTx;
    anaFrame.valid && aMap && aEp[`EPCFG_UP] && !aEp[`EPCFG_IS_SRV] && aPortEna;
  endsequence

  sequence rewPortTxSame;
    rewFrame.valid && !rewFrame.egressEndpointIndexValid && rewFrame.port == anaFrame.port;
  endsequence

  stage_lookup_a: assert property ((anaFrame.valid && rewFrame.valid) |=>
    (anaResult.valid && rewResult.valid))
    else $error("stage lookup result missing");
  ipt_select_a: assert property ((anaFrame.valid && aMap) |=>
    (anaResult.svcOn && anaResult.svcIdx == $past(aTbl[`IPT_IDX_LSB +: `EP_IDX_W])))
    else $error("analyzer table mapping not taken");
  egress_select_a: assert property ((rewFrame.valid && rMap) |=>
    (rewResult.svcOn && rewResult.svcIdx == $past(rewFrame.egressEndpointIndex)))
    else $error("rewriter action mapping not taken");
  port_fallback_a: assert property ((anaFrame.valid && !aTbl[`IPT_ENA] && aPortEna) |=>
    (!anaResult.svcOn && anaResult.portOn && anaResult.processed))
    else $error("unmapped frame not on port endpoint");
  port_disabled_a: assert property ((anaFrame.valid && !aTbl[`IPT_ENA] && !aPortEna) |=>
    (!anaResult.processed && !anaResult.portOn && !anaResult.discard))
    else $error("disabled port endpoint processed a frame");
  port_count_a: assert property (anaPortOnly |=>
    (st_ff.portRx[$past(anaFrame.port)] == $past(st_ff.portRx[anaFrame.port]) + 1))
    else $error("port endpoint count wrong");
  facing_side_a: assert property ((anaFrame.valid && aMap && rewFrame.valid && rMap) |=>
    (anaResult.tx == $past(aEp[`EPCFG_UP]) && rewResult.tx == !$past(rEp[`EPCFG_UP])))
    else $error("facing direction mapped to wrong side");
  server_layer_a: assert property ((anaFrame.valid && aMap && !rewFrame.valid) |=>
    (anaResult.srvOn == $past(aEp[`EPCFG_SRV_ENA] && st_ff.epCfg[aEp[`EPCFG_SRV_LSB +:
     `EP_IDX_W]][`EPCFG_ENA] && int'(aEp[`EPCFG_SRV_LSB +: `EP_IDX_W]) < NUM_EP)))
    else $error("server layer selection wrong");
  up_server_a: assert property ((anaFrame.valid && aMap && aEp[`EPCFG_UP]
    && aEp[`EPCFG_IS_SRV] && anaFrame.isOam) |=> (!anaResult.portOn && anaResult.svcOn))
    else $error("up server touched port counters");
  shared_slot_a: assert property ((anaUpSvcTx and rewPortTxSame) |=>
    (st_ff.portTx[$past(anaFrame.port)] == $past(st_ff.portTx[anaFrame.port]) + 2
     || !$past(st_ff.portCfg[rewFrame.port][`PORTCFG_ENA])))
    else $error("shared counter lost an increment");

endmodule // oam_endpoint_lookup

`default_nettype wire

// >>> hw/oam_lookup_consts.svh
// Constants for the endpoint lookup block: widths, register map, field positions.
// Assumes a 12-bit AXI4-Lite byte address; each block of registers has room for 64 words.
`ifndef OAM_LOOKUP_CONSTS_SVH
`define OAM_LOOKUP_CONSTS_SVH

// ==========================================================================
// Widths
`define EP_IDX_W 6
`define PORT_IDX_W 3
`define SIDX_W 6
`define AXI_AW 12
`define AXI_DW 32

// ==========================================================================
// Register blocks, selected by address bits 11:8, word index in bits 7:2
`define BLK_IPT 4'h1
`define BLK_EPCFG 4'h2
`define BLK_PORTCFG 4'h3
`define BLK_SVC_RX 4'h4
`define BLK_SVC_TX 4'h5
`define BLK_PORT_RX 4'h6
`define BLK_PORT_TX 4'h7
`define BLK_LSB 8
`define IDX_LSB 2

// ==========================================================================
// Per-service-index table word
`define IPT_ENA 0
`define IPT_IDX_LSB 8
`define IPT_MASK 32'h0000_3f01

// Endpoint configuration word
`define EPCFG_ENA 0
`define EPCFG_UP 1
`define EPCFG_IS_SRV 2
`define EPCFG_SRV_ENA 3
`define EPCFG_DISC 4
`define EPCFG_SRV_LSB 8
`define EPCFG_MASK 32'h0000_3f1f

// Port endpoint configuration word
`define PORTCFG_ENA 0
`define PORTCFG_DISC 1
`define PORTCFG_MASK 32'h0000_0003

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> hw/oam_lookup_pkg.sv
// Types shared by the endpoint lookup block and its surroundings.
// Assumes oam_lookup_consts.svh is on the include path.
`include "oam_lookup_consts.svh"
`default_nettype none

package oam_lookup_pkg;

  // ========================================================================
  // Frame descriptors from the two pipeline stages
  typedef struct packed {
    logic valid;
    logic isOam;
    logic [`PORT_IDX_W-1:0] port;
    logic [`SIDX_W-1:0] serviceIndex;
  } ana_frame_s;

  typedef struct packed {
    logic valid;
    logic isOam;
    logic [`PORT_IDX_W-1:0] port;
    logic egressEndpointIndexValid;
    logic [`EP_IDX_W-1:0] egressEndpointIndex;
  } rew_frame_s;

  // Result of one lookup: who is active and which counters it touched
  typedef struct packed {
    logic valid;
    logic processed;
    logic discard;
    logic tx;
    logic svcOn;
    logic [`EP_IDX_W-1:0] svcIdx;
    logic srvOn;
    logic [`EP_IDX_W-1:0] srvIdx;
    logic portOn;
    logic [`PORT_IDX_W-1:0] port;
  } lookup_s;

  // ========================================================================
  // AXI4-Lite carriers
  typedef struct packed {
    logic awvalid;
    logic [`AXI_AW-1:0] awaddr;
    logic wvalid;
    logic [`AXI_DW-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`AXI_AW-1:0] araddr;
    logic rready;
  } axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [`AXI_DW-1:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_s;

endpackage

`default_nettype wire

// >>> test/stage_model.sv
// Model of the analyzer and rewriter stages that hand frame descriptors to the lookup.
// Assumes requests from the bench change just after a rising edge of clk.
`default_nettype none

module stage_model (
  input wire logic clk,
  input wire logic nrst,
  input wire oam_lookup_pkg::ana_frame_s anaReq,
  input wire oam_lookup_pkg::rew_frame_s rewReq,
  output var oam_lookup_pkg::ana_frame_s anaFrame,
  output var oam_lookup_pkg::rew_frame_s rewFrame
);
  timeunit 1ns;
  timeprecision 1ps;
  import oam_lookup_pkg::*;

  // ========================================================================
  // Descriptor registers
  // one descriptor per stage
  // Idle fields flip each cycle so stale values never look meaningful
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      anaFrame <= '0;
      rewFrame <= '0;
    end else begin
      anaFrame <= anaReq.valid ? anaReq : ~anaFrame & ~(ana_frame_s'(1) << $bits(anaFrame) - 1);
      rewFrame <= rewReq.valid ? rewReq : ~rewFrame & ~(rew_frame_s'(1) << $bits(rewFrame) - 1);
    end
  end
endmodule // stage_model

`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the endpoint lookup: AXI4-Lite setup, frames, counter reads.
// Assumes the package, the lookup block and the stage model are compiled first.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import oam_lookup_pkg::*;

  logic clk = 1'b0;
  logic nrst = 1'b0;
  ana_frame_s anaReq = '0;
  rew_frame_s rewReq = '0;
  ana_frame_s anaFrame;
  rew_frame_s rewFrame;
  lookup_s anaResult;
  lookup_s rewResult;
  axi_req_s req = '0;
  axi_rsp_s axiRsp;
  int errors = 0;
  int n_tests = 0;

  // ========================================================================
  // Clock, design and stage model
  always #4 clk = ~clk;

  oam_endpoint_lookup oam_endpoint_lookup_i (
    .clk(clk), .nrst(nrst), .anaFrame(anaFrame), .rewFrame(rewFrame),
    .anaResult(anaResult), .rewResult(rewResult), .axiReq(req), .axiRsp(axiRsp));

  stage_model stage_model_i (
    .clk(clk), .nrst(nrst), .anaReq(anaReq), .rewReq(rewReq),
    .anaFrame(anaFrame), .rewFrame(rewFrame));

  // ========================================================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Address and data offered together, bready held until the response
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.bready <= 1'b1;
    // Waits as long as it takes; only the watchdog ends a hang
    do begin
      @(posedge clk);
      if (req.awvalid && axiRsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && axiRsp.wready) req.wvalid <= 1'b0;
    end while (!axiRsp.bvalid);
    req.bready <= 1'b0;
    chk("bresp", 32'(axiRsp.bresp), 32'(er));
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (req.arvalid && axiRsp.arready) req.arvalid <= 1'b0;
    end while (!axiRsp.rvalid);
    req.rready <= 1'b0;
    chk($sformatf("rdata %h", a), axiRsp.rdata, ed);
    chk("rresp", 32'(axiRsp.rresp), 32'(er));
  endtask

  function automatic logic [6:0] flg(input lookup_s x);
    return {x.valid, x.processed, x.discard, x.tx, x.svcOn, x.srvOn, x.portOn};
  endfunction

  function automatic ana_frame_s af(input logic o, input logic [2:0] p, input logic [5:0] s);
    return '{1'b1, o, p, s};
  endfunction

  function automatic rew_frame_s rf(input logic o, input logic [2:0] p, input logic v,
                                    input logic [5:0] i);
    return '{1'b1, o, p, v, i};
  endfunction

  // One frame into each stage; results land one edge after the model hands them on
  task automatic frm(input ana_frame_s a, input rew_frame_s r, input logic [6:0] ea,
                     input logic [6:0] er);
    @(posedge clk);
    anaReq <= a;
    rewReq <= r;
    @(posedge clk);
    anaReq.valid <= 1'b0;
    rewReq.valid <= 1'b0;
    @(posedge clk);
    #1;
    chk("ana flags", 32'(flg(anaResult)), 32'(ea));
    chk("rew flags", 32'(flg(rewResult)), 32'(er));
    chk("ana port", 32'(anaResult.port), 32'(a.port));
    chk("rew port", 32'(rewResult.port), 32'(r.port));
  endtask

  // ========================================================================
  // Scenarios
  task automatic t_regs();
    rd(12'h20c, 32'h0, 2'h0);
    wr(12'h000, 32'h1, 2'h2);
    rd(12'h000, 32'h0, 2'h2);
    wr(12'h20c, 32'hffff_ffff, 2'h0);
    rd(12'h20c, 32'h0000_3f1f, 2'h0);
    wr(12'h40c, 32'h5, 2'h0);
    rd(12'h40c, 32'h0, 2'h0);
  endtask

  task automatic t_port();
    wr(12'h304, 32'h1, 2'h0);
    frm(af(1'b1, 3'h1, 6'h00), rf(1'b0, 3'h1, 1'b0, 6'h00), 7'h61, 7'h69);
    rd(12'h604, 32'h1, 2'h0);
    rd(12'h704, 32'h1, 2'h0);
    frm(af(1'b1, 3'h2, 6'h00), rf(1'b1, 3'h2, 1'b0, 6'h00), 7'h40, 7'h48);
    rd(12'h608, 32'h0, 2'h0);
  endtask

  // Software maps the flow to one endpoint in both stages
  task automatic t_down();
    wr(12'h210, 32'h0000_0005, 2'h0);
    wr(12'h20c, 32'h0000_0409, 2'h0);
    wr(12'h114, 32'h0000_0301, 2'h0);
    frm(af(1'b1, 3'h1, 6'h05), rf(1'b1, 3'h1, 1'b1, 6'h03), 7'h67, 7'h6f);
    rd(12'h40c, 32'h1, 2'h0);
    rd(12'h50c, 32'h1, 2'h0);
    rd(12'h410, 32'h1, 2'h0);
    rd(12'h510, 32'h1, 2'h0);
    rd(12'h604, 32'h2, 2'h0);
    rd(12'h704, 32'h2, 2'h0);
    wr(12'h118, 32'h0000_0401, 2'h0);
    frm(af(1'b1, 3'h1, 6'h06), rf(1'b1, 3'h1, 1'b1, 6'h04), 7'h65, 7'h6d);
    rd(12'h410, 32'h2, 2'h0);
    rd(12'h604, 32'h3, 2'h0);
  endtask

  task automatic t_up();
    wr(12'h21c, 32'h0000_0007, 2'h0);
    wr(12'h218, 32'h0000_070b, 2'h0);
    wr(12'h11c, 32'h0000_0601, 2'h0);
    // Both stages hit the same port counter in one slot
    frm(af(1'b1, 3'h1, 6'h05), rf(1'b1, 3'h1, 1'b1, 6'h06), 7'h67, 7'h67);
    rd(12'h604, 32'h5, 2'h0);
    rd(12'h418, 32'h1, 2'h0);
    rd(12'h41c, 32'h1, 2'h0);
    rd(12'h410, 32'h3, 2'h0);
    frm(af(1'b1, 3'h1, 6'h07), rf(1'b1, 3'h1, 1'b1, 6'h07), 7'h6f, 7'h64);
    rd(12'h41c, 32'h2, 2'h0);
    rd(12'h604, 32'h5, 2'h0);
    rd(12'h51c, 32'h1, 2'h0);
    rd(12'h704, 32'h4, 2'h0);
  endtask

  task automatic t_data();
    wr(12'h218, 32'h0000_071b, 2'h0);
    wr(12'h304, 32'h3, 2'h0);
    frm(af(1'b0, 3'h1, 6'h07), rf(1'b0, 3'h1, 1'b0, 6'h00), 7'h7f, 7'h79);
    rd(12'h518, 32'h2, 2'h0);
    // Index present but enable or valid bit clear: falls to the port
    wr(12'h120, 32'h0000_0300, 2'h0);
    frm(af(1'b1, 3'h1, 6'h08), rf(1'b0, 3'h1, 1'b0, 6'h03), 7'h61, 7'h79);
    rd(12'h40c, 32'h2, 2'h0);
    // Up server own PDU in the analyzer, then an analyzer-only port frame
    wr(12'h124, 32'h0000_0701, 2'h0);
    frm(af(1'b1, 3'h1, 6'h09), '0, 7'h6c, 7'h00);
    frm(af(1'b1, 3'h1, 6'h00), '0, 7'h61, 7'h00);
    rd(12'h604, 32'h7, 2'h0);
    rd(12'h704, 32'h7, 2'h0);
    rd(12'h51c, 32'h3, 2'h0);
  endtask

  // ========================================================================
  // Run control
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    req.wstrb <= 4'hf;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_port();
    t_down();
    t_up();
    t_data();
    end_of_test();
  end

  // Whole run is a few hundred cycles at most; far past that means a hang
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test();
  end
endmodule // tb_top

`default_nettype wire
